// *** rtl/ojag_top.sv ***
// Operand and jump address generator of an 8-bit controller core.
// What this block does
// - Direct mode: operand address from instruction byte.
// - Indirect mode: selected pointer is the address.
// - Post-modify: access at pointer, then step it.
// - Immediate: operand fetched from byte after opcode.
// - Short load: nibble into pointer, upper cleared.
// - Table load: high byte plus accumulator, restore.
// - Counter is fifteen bits; top bit unused.
// - Relative branch: six-bit distance, -31 to +32.
// - Near branch replaces low twelve counter bits.
// - Far branch loads all fifteen counter bits.
// - Table jump: fetched byte becomes counter low.
// - Vector select loads two adjacent program bytes.
`timescale 1ns/1ps
`default_nettype none

module ojag_top (
	// Clock and reset.
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	// Command port from the instruction decoder.
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire ojag_pkg::ojag_op_t  cmd_op,
	input  wire logic                cmd_ptr_sel,
	input  wire ojag_pkg::ojag_post_t cmd_post,
	input  wire logic [11:0]         cmd_field,
	input  wire logic [7:0]          cmd_byte1,
	input  wire logic [7:0]          cmd_byte2,
	input  wire logic [7:0]          acc,
	// Program memory read port, data in the same cycle as the request.
	output logic                     pm_req,
	output logic [14:0]              pm_addr,
	input  wire logic [7:0]          pm_rdata,
	// Data memory address port.
	output logic                     dm_req,
	output logic [7:0]               dm_addr,
	// Results.
	output logic                     done,
	output logic                     acc_load_valid,
	output logic [7:0]               acc_load_data,
	output logic                     operand_valid,
	output logic [7:0]               operand_data,
	// Architectural state.
	output logic [7:0]               ptr_first,
	output logic [7:0]               ptr_second,
	output logic [7:0]               pc_high_byte,
	output logic [7:0]               pc_low_byte
);

	// ==========================================================================
	// State
	typedef enum logic [1:0] {
		OJAG_ST_IDLE,
		OJAG_ST_PM_WAIT,
		OJAG_ST_VEC_HI,
		OJAG_ST_VEC_LO
	} ojag_state_t;

	typedef struct packed {
		ojag_state_t        st;
		ojag_pkg::ojag_op_t op;
		logic [14:0]        pc;
		logic [7:0]         ptr_first;
		logic [7:0]         ptr_second;
		logic               pm_req;
		logic [14:0]        pm_addr;
		logic               dm_req;
		logic [7:0]         dm_addr;
		logic               done;
		logic               acc_valid;
		logic [7:0]         acc_data;
		logic               opnd_valid;
		logic [7:0]         opnd_data;
		logic [7:0]         vec_hi;
	} ojag_regs_t;

	ojag_regs_t  r;
	ojag_regs_t  next_r;
	logic        cmd_fire;
	logic [14:0] pc_plus_one;
	logic [14:0] pc_plus_two;
	logic [14:0] jump_pc;
	logic [7:0]  ptr_sel_val;
	logic [7:0]  ptr_stepped;

	// ==========================================================================
	// Target calculation
	ojag_pc_calc u_pc_calc (
		.pc          (r.pc),
		.op          (cmd_op),
		.field       (cmd_field),
		.byte1       (cmd_byte1),
		.byte2       (cmd_byte2),
		.pc_plus_one (pc_plus_one),
		.pc_plus_two (pc_plus_two),
		.jump_pc     (jump_pc)
	);

	// Commands are taken only while idle, so a multi-cycle fetch never overlaps.
	assign cmd_ready = (r.st == OJAG_ST_IDLE);
	assign cmd_fire  = cmd_valid && cmd_ready;

	// Selected pointer and its post-modified value; 8-bit arithmetic wraps freely.
	assign ptr_sel_val = (cmd_ptr_sel == ojag_pkg::PTR_SEL_FIRST) ? r.ptr_first : r.ptr_second;
	assign ptr_stepped = (cmd_post == ojag_pkg::OJAG_POST_DEC) ? ptr_sel_val - ojag_pkg::PTR_STEP
		: ptr_sel_val + ojag_pkg::PTR_STEP;

	// ==========================================================================
	// Next state. Strobes default low, so one stays high past a cycle only when set again, as pm_req is for a vector.
	always_comb begin
		next_r            = r;
		next_r.pm_req     = 1'b0;
		next_r.dm_req     = 1'b0;
		next_r.done       = 1'b0;
		next_r.acc_valid  = 1'b0;
		next_r.opnd_valid = 1'b0;
		case (r.st)
			OJAG_ST_IDLE: begin
				if (cmd_fire) begin
					next_r.op = cmd_op;
					case (cmd_op)
						ojag_pkg::OJAG_OP_DIRECT: begin
							next_r.dm_req  = 1'b1;
							next_r.dm_addr = cmd_byte1;
							next_r.pc      = pc_plus_two;
							next_r.done    = 1'b1;
						end
						ojag_pkg::OJAG_OP_INDIRECT: begin
							next_r.dm_req  = 1'b1;
							next_r.dm_addr = ptr_sel_val;
							next_r.pc      = pc_plus_one;
							next_r.done    = 1'b1;
							// The access uses the old value; the step lands with completion.
							if (cmd_post != ojag_pkg::OJAG_POST_NONE) begin
								if (cmd_ptr_sel == ojag_pkg::PTR_SEL_FIRST) begin
									next_r.ptr_first = ptr_stepped;
								end else begin
									next_r.ptr_second = ptr_stepped;
								end
							end
						end
						ojag_pkg::OJAG_OP_IMMEDIATE: begin
							next_r.pm_req  = 1'b1;
							next_r.pm_addr = pc_plus_one;
							next_r.st      = OJAG_ST_PM_WAIT;
						end
						ojag_pkg::OJAG_OP_IMM_SHORT: begin
							next_r.ptr_first = {ojag_pkg::SHORT_UPPER,
								cmd_field[ojag_pkg::NIBBLE_MSB:0]};
							next_r.pc        = pc_plus_one;
							next_r.done      = 1'b1;
						end
						ojag_pkg::OJAG_OP_TABLE_LOAD,
						ojag_pkg::OJAG_OP_TABLE_JUMP: begin
							// Accumulator stands in for the low byte only on the address.
							next_r.pm_req  = 1'b1;
							next_r.pm_addr = {r.pc[14:ojag_pkg::PC_HI_LSB], acc};
							next_r.st      = OJAG_ST_PM_WAIT;
						end
						ojag_pkg::OJAG_OP_REL_BRANCH,
						ojag_pkg::OJAG_OP_NEAR_ABS,
						ojag_pkg::OJAG_OP_FAR_ABS: begin
							next_r.pc   = jump_pc;
							next_r.done = 1'b1;
						end
						ojag_pkg::OJAG_OP_VECTOR: begin
							next_r.pm_req  = 1'b1;
							next_r.pm_addr = {cmd_byte1[6:0], cmd_byte2};
							next_r.st      = OJAG_ST_VEC_HI;
						end
						default: begin
							next_r.done = 1'b1;
						end
					endcase
				end
			end
			OJAG_ST_PM_WAIT: begin
				next_r.done = 1'b1;
				next_r.st   = OJAG_ST_IDLE;
				case (r.op)
					ojag_pkg::OJAG_OP_IMMEDIATE: begin
						next_r.opnd_valid = 1'b1;
						next_r.opnd_data  = pm_rdata;
						next_r.pc         = pc_plus_two;
					end
					ojag_pkg::OJAG_OP_TABLE_LOAD: begin
						// The counter was never disturbed, so the low byte is restored.
						next_r.acc_valid = 1'b1;
						next_r.acc_data  = pm_rdata;
						next_r.pc        = pc_plus_one;
					end
					ojag_pkg::OJAG_OP_TABLE_JUMP: begin
						next_r.pc = {r.pc[14:ojag_pkg::PC_HI_LSB], pm_rdata};
					end
					default: begin
						next_r.pc = r.pc;
					end
				endcase
			end
			OJAG_ST_VEC_HI: begin
				next_r.vec_hi  = pm_rdata;
				next_r.pm_req  = 1'b1;
				next_r.pm_addr = r.pm_addr + ojag_pkg::LEN_ONE;
				next_r.st      = OJAG_ST_VEC_LO;
			end
			OJAG_ST_VEC_LO: begin
				next_r.pc   = {r.vec_hi[6:0], pm_rdata};
				next_r.done = 1'b1;
				next_r.st   = OJAG_ST_IDLE;
			end
			default: begin
				next_r.st = OJAG_ST_IDLE;
			end
		endcase
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			r            <= '0;
			r.st         <= OJAG_ST_IDLE;
			r.op         <= ojag_pkg::OJAG_OP_DIRECT;
			r.pc         <= ojag_pkg::PC_RST;
			r.ptr_first  <= ojag_pkg::PTR_RST;
			r.ptr_second <= ojag_pkg::PTR_RST;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================================
	// Outputs, all straight from flip-flops.
	assign pm_req         = r.pm_req;
	assign pm_addr        = r.pm_addr;
	assign dm_req         = r.dm_req;
	assign dm_addr        = r.dm_addr;
	assign done           = r.done;
	assign acc_load_valid = r.acc_valid;
	assign acc_load_data  = r.acc_data;
	assign operand_valid  = r.opnd_valid;
	assign operand_data   = r.opnd_data;
	assign ptr_first      = r.ptr_first;
	assign ptr_second     = r.ptr_second;
	assign pc_high_byte   = {ojag_pkg::PC_HIGH_UNUSED, r.pc[14:ojag_pkg::PC_HI_LSB]};
	assign pc_low_byte    = r.pc[7:0];

	// ==========================================================================
	// Assertions
	default clocking ojag_cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_fire(ojag_pkg::ojag_op_t o);
		cmd_fire && cmd_op == o;
	endsequence

	sequence s_table_req;
		s_fire(ojag_pkg::OJAG_OP_TABLE_LOAD) ##1
		(pm_req && pm_addr == {$past(r.pc[14:8]), $past(acc)});
	endsequence

	a_direct_addr: assert property (s_fire(ojag_pkg::OJAG_OP_DIRECT) |=> dm_req
		&& done && dm_addr == $past(cmd_byte1)) else $error("direct address wrong");
	a_indirect_addr: assert property (s_fire(ojag_pkg::OJAG_OP_INDIRECT)
		##0 !cmd_ptr_sel |=> dm_req && dm_addr == $past(r.ptr_first))
		else $error("indirect address wrong");
	a_post_step: assert property (s_fire(ojag_pkg::OJAG_OP_INDIRECT)
		##0 (cmd_ptr_sel && cmd_post == ojag_pkg::OJAG_POST_DEC) |=> ptr_second
		== 8'($past(r.ptr_second) - 8'h01) && dm_addr == $past(r.ptr_second))
		else $error("post step wrong");
	a_imm_fetch: assert property (s_fire(ojag_pkg::OJAG_OP_IMMEDIATE) |=> pm_req
		&& pm_addr == 15'($past(r.pc) + 15'h1) ##1 operand_valid && done
		&& operand_data == $past(pm_rdata)) else $error("immediate fetch wrong");
	a_short_load: assert property (s_fire(ojag_pkg::OJAG_OP_IMM_SHORT) |=>
		ptr_first == {4'h0, $past(cmd_field[3:0])}) else $error("short load wrong");
	a_table_load: assert property (s_table_req |=> acc_load_valid
		&& acc_load_data == $past(pm_rdata)
		&& pc_low_byte == 8'($past(r.pc[7:0], 2) + 8'h01)) else $error("table load wrong");
	a_pc_top_unused: assert property (pc_high_byte[7] == 1'b0)
		else $error("counter top bit set");
	a_rel_branch: assert property (s_fire(ojag_pkg::OJAG_OP_REL_BRANCH) |=>
		15'(r.pc - $past(r.pc) + 15'h1f) == {9'h000, $past(cmd_field[5:0])})
		else $error("relative branch wrong");
	a_near_abs: assert property (s_fire(ojag_pkg::OJAG_OP_NEAR_ABS) |=>
		r.pc == {$past(r.pc[14:12]), $past(cmd_field)}) else $error("near branch wrong");
	a_far_abs: assert property (s_fire(ojag_pkg::OJAG_OP_FAR_ABS) |=>
		r.pc == {$past(cmd_byte1[6:0]), $past(cmd_byte2)}) else $error("far branch wrong");
	a_table_jump: assert property (s_fire(ojag_pkg::OJAG_OP_TABLE_JUMP) ##1 pm_req
		|=> done && pc_low_byte == $past(pm_rdata)
		&& pc_high_byte == $past(pc_high_byte, 2)) else $error("table jump wrong");
	a_vector_load: assert property (s_fire(ojag_pkg::OJAG_OP_VECTOR) |=> pm_req
		##1 pm_req && pm_addr == 15'($past(pm_addr) + 15'h1) ##1 done && r.pc
		== {$past(pm_rdata[6:0], 2), $past(pm_rdata)}) else $error("vector load wrong");

endmodule
`default_nettype wire

// *** rtl/ojag_pkg.sv ***
// Shared constants and enumerations for the operand and jump address generator.
`default_nettype none

package ojag_pkg;

	// ==========================================================================
	// Widths
	localparam int unsigned PC_W    = 15;
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned FIELD_W = 12;

	// ==========================================================================
	// Reset values
	localparam logic [14:0] PC_RST  = 15'h0000;
	localparam logic [7:0]  PTR_RST = 8'h00;

	// ==========================================================================
	// Instruction lengths and field layout
	localparam logic [14:0] LEN_ONE         = 15'h0001;
	localparam logic [14:0] LEN_TWO         = 15'h0002;
	localparam int unsigned DISP_MSB        = 5;
	localparam logic [14:0] DISP_BIAS       = 15'h001f;
	localparam int unsigned NIBBLE_MSB      = 3;
	localparam logic [3:0]  SHORT_UPPER     = 4'h0;
	localparam int unsigned PC_HI_LSB       = 8;
	localparam int unsigned NEAR_KEEP_LSB   = 12;
	localparam logic [7:0]  PTR_STEP        = 8'h01;
	localparam logic        PTR_SEL_FIRST   = 1'b0;
	localparam logic        PC_HIGH_UNUSED  = 1'b0;

	// ==========================================================================
	// Operations accepted on the command port
	typedef enum logic [3:0] {
		OJAG_OP_DIRECT,
		OJAG_OP_INDIRECT,
		OJAG_OP_IMMEDIATE,
		OJAG_OP_IMM_SHORT,
		OJAG_OP_TABLE_LOAD,
		OJAG_OP_REL_BRANCH,
		OJAG_OP_NEAR_ABS,
		OJAG_OP_FAR_ABS,
		OJAG_OP_TABLE_JUMP,
		OJAG_OP_VECTOR
	} ojag_op_t;

	// Pointer modification after an indirect access.
	typedef enum logic [1:0] {
		OJAG_POST_NONE,
		OJAG_POST_INC,
		OJAG_POST_DEC
	} ojag_post_t;

endpackage
`default_nettype wire

// *** rtl/ojag_pc_calc.sv ***
// Combinational program counter target calculation for sequential and jump flow.
`timescale 1ns/1ps
`default_nettype none

module ojag_pc_calc (
	// Current state.
	input  wire logic [14:0]      pc,
	input  wire ojag_pkg::ojag_op_t op,
	// Instruction fields.
	input  wire logic [11:0]      field,
	input  wire logic [7:0]       byte1,
	input  wire logic [7:0]       byte2,
	// Results.
	output logic      [14:0]      pc_plus_one,
	output logic      [14:0]      pc_plus_two,
	output logic      [14:0]      jump_pc
);

	// ==========================================================================
	// Sequential successors wrap in 15 bits, like the counter itself.
	assign pc_plus_one = pc + ojag_pkg::LEN_ONE;
	assign pc_plus_two = pc + ojag_pkg::LEN_TWO;

	// ==========================================================================
	// Jump targets. The six-bit field carries the distance with a bias of 31,
	// so codes 0 to 63 span -31 to +32 and no sign bit is wasted.
	always_comb begin
		jump_pc = pc;
		case (op)
			ojag_pkg::OJAG_OP_REL_BRANCH: begin
				jump_pc = pc + {9'h000, field[ojag_pkg::DISP_MSB:0]} - ojag_pkg::DISP_BIAS;
			end
			ojag_pkg::OJAG_OP_NEAR_ABS: begin
				jump_pc = {pc[14:ojag_pkg::NEAR_KEEP_LSB], field};
			end
			ojag_pkg::OJAG_OP_FAR_ABS: begin
				jump_pc = {byte1[6:0], byte2};
			end
			default: begin
				jump_pc = pc;
			end
		endcase
	end

endmodule
`default_nettype wire

// *** verif/ojag_pmem.sv ***
// Program memory model that answers reads in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Memory model
module ojag_pmem (
	// Clock.
	input  wire logic        core_clk,
	// Read port.
	input  wire logic        pm_req,
	input  wire logic [14:0] pm_addr,
	output logic      [7:0]  pm_rdata
);
	logic [7:0] junk = 8'h00;

	// Idle data alternates so a late sample never sees the last read.
	always @(posedge core_clk) begin
		junk <= ~junk ^ 8'h3c;
	end

	// Contents are a fixed hash of the address.
	assign pm_rdata = pm_req ? (pm_addr[7:0] ^ {1'b0, pm_addr[14:8]} ^ 8'ha5) : junk;
endmodule
`default_nettype wire

// *** verif/ojag_top_tb.sv ***
// Self-checking bench for the operand and jump address generator.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Bench
module ojag_top_tb;
	logic                 core_clk = 1'b0;
	logic                 reset_n = 1'b0;
	logic                 cmd_valid = 1'b0;
	logic                 cmd_ptr_sel = 1'b0;
	ojag_pkg::ojag_op_t   cmd_op = ojag_pkg::OJAG_OP_DIRECT;
	ojag_pkg::ojag_post_t cmd_post = ojag_pkg::OJAG_POST_NONE;
	logic [11:0]          cmd_field = 12'h000;
	logic [7:0]           cmd_byte1 = 8'h00;
	logic [7:0]           cmd_byte2 = 8'h00;
	logic [7:0]           acc = 8'h00;
	wire logic            cmd_ready, pm_req, dm_req, done, acc_load_valid, operand_valid;
	wire logic [14:0]     pm_addr;
	wire logic [7:0]      pm_rdata, dm_addr, acc_load_data, operand_data;
	wire logic [7:0]      ptr_first, ptr_second, pc_high_byte, pc_low_byte;
	int                   tests_run = 0;
	int                   miscompares = 0;
	int                   npm, lat;
	logic                 dmq, opv, alv;
	logic [14:0]          pa [2];

	// Clock at 200 MHz.
	always #2.5 core_clk = ~core_clk;

	ojag_top dut (.core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ptr_sel(cmd_ptr_sel),
		.cmd_post(cmd_post), .cmd_field(cmd_field), .cmd_byte1(cmd_byte1),
		.cmd_byte2(cmd_byte2), .acc(acc), .pm_req(pm_req), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .dm_req(dm_req), .dm_addr(dm_addr), .done(done),
		.acc_load_valid(acc_load_valid), .acc_load_data(acc_load_data),
		.operand_valid(operand_valid), .operand_data(operand_data),
		.ptr_first(ptr_first), .ptr_second(ptr_second),
		.pc_high_byte(pc_high_byte), .pc_low_byte(pc_low_byte));

	ojag_pmem pmem (.core_clk(core_clk), .pm_req(pm_req), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata));

	// ==========
	// Helpers
	function automatic logic [7:0] mf(input logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]} ^ 8'ha5;
	endfunction

	function automatic logic [14:0] cur_pc();
		return {pc_high_byte[6:0], pc_low_byte};
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Offers one command, holds it until taken and logs strobes until done.
	task automatic run(input ojag_pkg::ojag_op_t op, input logic [11:0] fld = 12'h000,
		input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00,
		input logic [7:0] a = 8'h00, input logic sel = 1'b0,
		input ojag_pkg::ojag_post_t post = ojag_pkg::OJAG_POST_NONE);
		int n;
		// One edge passes first, so a back-to-back call never re-drives valid in one step.
		@(negedge core_clk);
		cmd_op = op;
		cmd_field = fld;
		cmd_byte1 = b1;
		cmd_byte2 = b2;
		acc = a;
		cmd_ptr_sel = sel;
		cmd_post = post;
		cmd_valid = 1'b1;
		for (n = 0; n < 8 && cmd_ready !== 1'b1; n++) begin
			@(negedge core_clk);
		end
		@(negedge core_clk);
		cmd_valid = 1'b0;
		npm = 0;
		dmq = 1'b0;
		lat = 0;
		for (n = 1; n < 6 && lat == 0; n++) begin
			if (pm_req === 1'b1) begin
				pa[npm % 2] = pm_addr;
				npm++;
			end
			if (dm_req === 1'b1) dmq = 1'b1;
			if (done === 1'b1) begin
				lat = n;
				opv = operand_valid;
				alv = acc_load_valid;
			end else begin
				@(negedge core_clk);
			end
		end
		check("done", 1'(lat != 0), 1'b1);
		check("pc_top_bit", pc_high_byte[7], 1'b0);
	endtask

	// ==========
	// Scenarios
	task automatic t_direct();
		logic [14:0] p;
		p = cur_pc();
		run(ojag_pkg::OJAG_OP_DIRECT, 12'h000, 8'h05);
		check("dm_req", dmq, 1'b1);
		check("dm_addr", dm_addr, 8'h05);
		check("pc", cur_pc(), p + 15'h0002);
	endtask

	// Pointers walk through zero both ways to show the wrap.
	task automatic t_ptr();
		logic [7:0] e [2];
		logic [7:0] nw;
		logic       s;
		ojag_pkg::ojag_post_t m;
		run(ojag_pkg::OJAG_OP_IMM_SHORT, 12'hab7);
		check("ptr_first", ptr_first, 8'h07);
		run(ojag_pkg::OJAG_OP_IMM_SHORT, 12'h5f0);
		check("ptr_first", ptr_first, 8'h00);
		e[0] = 8'h00;
		e[1] = 8'h00;
		for (int i = 0; i < 6; i++) begin
			s = i[0];
			m = (i < 2) ? ojag_pkg::OJAG_POST_NONE :
				(i < 4) ? ojag_pkg::OJAG_POST_DEC : ojag_pkg::OJAG_POST_INC;
			nw = (m == ojag_pkg::OJAG_POST_INC) ? e[s] + 8'h01 :
				(m == ojag_pkg::OJAG_POST_DEC) ? e[s] - 8'h01 : e[s];
			run(ojag_pkg::OJAG_OP_INDIRECT, 12'h000, 8'h00, 8'h00, 8'h00, s, m);
			check("dm_addr", dm_addr, e[s]);
			check("ptr_step", s ? ptr_second : ptr_first, nw);
			check("ptr_other", s ? ptr_first : ptr_second, e[!s]);
			e[s] = nw;
		end
	endtask

	task automatic t_imm();
		logic [14:0] p;
		p = cur_pc();
		run(ojag_pkg::OJAG_OP_IMMEDIATE);
		check("pm_addr", pa[0], p + 15'h0001);
		check("operand_valid", opv, 1'b1);
		check("operand", operand_data, mf(p + 15'h0001));
		check("pc", cur_pc(), p + 15'h0002);
	endtask

	task automatic t_branch();
		logic [14:0] p;
		logic [5:0]  codes [4] = '{6'h00, 6'h1f, 6'h29, 6'h3f};
		run(ojag_pkg::OJAG_OP_FAR_ABS, 12'h000, 8'hb6, 8'h25);
		check("pc", cur_pc(), 15'h3625);
		check("pc_high", pc_high_byte, 8'h36);
		run(ojag_pkg::OJAG_OP_NEAR_ABS, 12'h125);
		check("pc", cur_pc(), 15'h3125);
		// Code 0x20 would be a jump of plus one, which programs never hold.
		foreach (codes[i]) begin
			p = cur_pc();
			run(ojag_pkg::OJAG_OP_REL_BRANCH, {6'h00, codes[i]});
			check("pc", cur_pc(), p + {9'h000, codes[i]} - 15'h001f);
		end
	endtask

	task automatic t_table();
		run(ojag_pkg::OJAG_OP_FAR_ABS, 12'h000, 8'h04, 8'h35);
		run(ojag_pkg::OJAG_OP_TABLE_LOAD, 12'h000, 8'h00, 8'h00, 8'h1f);
		check("pm_addr", pa[0], 15'h041f);
		check("acc_valid", alv, 1'b1);
		check("acc_data", acc_load_data, mf(15'h041f));
		check("pc", cur_pc(), 15'h0436);
		run(ojag_pkg::OJAG_OP_TABLE_JUMP, 12'h000, 8'h00, 8'h00, 8'h26);
		check("pm_addr", pa[0], 15'h0426);
		check("pc", cur_pc(), {7'h04, mf(15'h0426)});
	endtask

	// The second vector byte sits across a 256-byte boundary.
	task automatic t_vector();
		logic [7:0] d0;
		d0 = mf(15'h02ff);
		run(ojag_pkg::OJAG_OP_VECTOR, 12'h000, 8'h02, 8'hff);
		check("pm_reads", 16'(npm), 16'h0002);
		check("pm_addr0", pa[0], 15'h02ff);
		check("pm_addr1", pa[1], 15'h0300);
		check("pc", cur_pc(), {d0[6:0], mf(15'h0300)});
	endtask

	// A reset in the middle of a fetch drops it, clears the state and the next command runs.
	task automatic t_reset();
		run(ojag_pkg::OJAG_OP_IMM_SHORT, 12'h009);
		@(negedge core_clk);
		cmd_op = ojag_pkg::OJAG_OP_VECTOR;
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		reset_n = 1'b0;
		check("ready_busy", cmd_ready, 1'b0);
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		check("ready_idle", cmd_ready, 1'b1);
		check("pc", cur_pc(), 15'h0000);
		check("ptr_first", ptr_first, 8'h00);
		run(ojag_pkg::OJAG_OP_DIRECT, 12'h000, 8'h4a);
		check("dm_addr", dm_addr, 8'h4a);
		check("pc", cur_pc(), 15'h0002);
	endtask

	// ==========
	// Main sequence
	initial begin
		repeat (10) @(negedge core_clk);
		reset_n = 1'b1;
		check("pc", cur_pc(), 15'h0000);
		check("ptr_second", ptr_second, 8'h00);
		t_direct();
		t_ptr();
		t_imm();
		t_branch();
		t_table();
		t_vector();
		t_reset();
		wrap_up();
	end

	// Watchdog well beyond the sixty-odd cycles the tests need.
	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
